// ===== shared/tcs_defines.svh
// Constants for the timer clock-domain synchronization shell.
// Assumes inclusion by bare name from design files.
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// Register selects seen by the bus side
`define TCS_SEL_CTRLB_CLR 3'h0
`define TCS_SEL_CTRLB_SET 3'h1
`define TCS_SEL_CONTROL_C 3'h2
`define TCS_SEL_COUNT 3'h3
`define TCS_SEL_PERIOD 3'h4
`define TCS_SEL_CC0 3'h5
`define TCS_SEL_CC1 3'h6
`define TCS_SEL_CTRLA_ON 3'h7

// Counting-clock ticks a transfer spends crossing the boundary
`define TCS_SYNC_TICKS 2'h2
`define TCS_TICK_CNT_ONE 2'h1
`define TCS_TICK_CNT_ZERO 2'h0
`define TCS_DIV_CNT_ONE 8'h01
`define TCS_DIV_CNT_ZERO 8'h00
`define TCS_DATA_ZERO 32'h0000_0000

`endif

// ===== shared/tcs_pkg.sv
// Types for the timer clock-domain synchronization shell.
// Assumes nothing of its surroundings.
package tcs_pkg;

  typedef enum logic [1:0] {
    TCS_IDLE,
    TCS_SYNC,
    TCS_DONE
  } tcs_state_t;

endpackage

// ===== rtl/tcs_sync_shell.sv
// Clocking, sleep and register-crossing shell of a paired timer unit.
// Assumes one system clock; the counting clock is a divided tick pulse.
`timescale 1ns/1ps
`include "tcs_defines.svh"

module tcs_sync_shell #(
  parameter int DATA_W = 32,
  parameter int EVT_W = 3,
  parameter int DMA_W = 3,
  parameter logic [7:0] GCLK_DIV = 8'h04
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Power and clock source
  input wire logic i_sleep,
  input wire logic i_gclk_run,
  // Bus request
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [2:0] i_req_sel,
  input wire logic [DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  // Bus answer
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_rdata,
  output logic o_busy,
  // Counting core side
  output logic o_pair_tick,
  output logic o_core_wr_stb,
  output logic [2:0] o_core_sel,
  output logic [DATA_W-1:0] o_core_wdata,
  output logic o_core_on,
  input wire logic [DATA_W-1:0] i_core_rdata,
  // Core requests toward the system
  input wire logic i_core_irq,
  input wire logic [EVT_W-1:0] i_core_evt,
  input wire logic [DMA_W-1:0] i_core_dma,
  output logic o_irq,
  output logic o_wake,
  output logic [EVT_W-1:0] o_evt,
  output logic [DMA_W-1:0] o_dma
);

  // ==========================================================
  // Counting-clock divider
  // ==========================================================
  logic [7:0] div_q;
  logic tick;

  // Not gated by sleep: only a stopped source halts counting
  assign tick = i_gclk_run && (div_q == GCLK_DIV - `TCS_DIV_CNT_ONE);
  // One tick serves both members of the pair
  assign o_pair_tick = tick;

  // Cycles since the last tick while the source runs; checks the divider
  logic [7:0] gap_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      gap_q <= `TCS_DIV_CNT_ZERO;
    else if (!i_gclk_run || tick)
      gap_q <= `TCS_DIV_CNT_ZERO;
    else
      gap_q <= gap_q + `TCS_DIV_CNT_ONE;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      div_q <= `TCS_DIV_CNT_ZERO;
    else if (i_gclk_run)
    begin
      if (tick)
        div_q <= `TCS_DIV_CNT_ZERO;
      else
        div_q <= div_q + `TCS_DIV_CNT_ONE;
    end
  end

  // ==========================================================
  // Crossing state machine
  // ==========================================================
  tcs_pkg::tcs_state_t state_q;
  logic [1:0] tick_cnt_q;
  logic wr_q;
  logic on_shadow_q;
  logic take;
  logic take_sync;
  logic last_tick;

  assign take = i_req_valid && o_req_ready;
  // Enable bit crosses on write only; its readback is local
  assign take_sync = take && (i_req_write ||
                     (i_req_sel != `TCS_SEL_CTRLA_ON));
  assign last_tick = tick &&
                     (tick_cnt_q == `TCS_SYNC_TICKS - `TCS_TICK_CNT_ONE);
  assign o_req_ready = (state_q == tcs_pkg::TCS_IDLE);
  assign o_busy = (state_q == tcs_pkg::TCS_SYNC);
  assign o_rsp_valid = (state_q == tcs_pkg::TCS_DONE);

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_q <= tcs_pkg::TCS_IDLE;
    else
    begin
      case (state_q)
        tcs_pkg::TCS_IDLE:
          if (take_sync)
            state_q <= tcs_pkg::TCS_SYNC;
          else if (take)
            state_q <= tcs_pkg::TCS_DONE;
        tcs_pkg::TCS_SYNC:
          if (last_tick)
            state_q <= tcs_pkg::TCS_DONE;
        tcs_pkg::TCS_DONE:
          state_q <= tcs_pkg::TCS_IDLE;
        default:
          state_q <= tcs_pkg::TCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tick_cnt_q <= `TCS_TICK_CNT_ZERO;
    else if (take)
      tick_cnt_q <= `TCS_TICK_CNT_ZERO;
    else if (state_q == tcs_pkg::TCS_SYNC && tick)
      tick_cnt_q <= tick_cnt_q + `TCS_TICK_CNT_ONE;
  end

  // Request latch toward the core
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_q <= 1'b0;
      o_core_sel <= `TCS_SEL_CTRLB_CLR;
      o_core_wdata <= `TCS_DATA_ZERO;
    end
    else if (take)
    begin
      wr_q <= i_req_write;
      o_core_sel <= i_req_sel;
      o_core_wdata <= i_req_wdata;
    end
  end

  // Write lands in the counting domain on the final tick
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_core_wr_stb <= 1'b0;
    else
      o_core_wr_stb <= (state_q == tcs_pkg::TCS_SYNC) &&
                       last_tick && wr_q;
  end

  // Core enable follows the crossed write; shadow reads back at once
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_core_on <= 1'b0;
      on_shadow_q <= 1'b0;
    end
    else
    begin
      if (take && i_req_write && i_req_sel == `TCS_SEL_CTRLA_ON)
        on_shadow_q <= i_req_wdata[0];
      if (state_q == tcs_pkg::TCS_SYNC && last_tick && wr_q &&
          o_core_sel == `TCS_SEL_CTRLA_ON)
        o_core_on <= o_core_wdata[0];
    end
  end

  // Read data: sampled from core on final tick, local for enable bit
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rsp_rdata <= `TCS_DATA_ZERO;
    else if (take && !i_req_write && i_req_sel == `TCS_SEL_CTRLA_ON)
      o_rsp_rdata <= {{(DATA_W-1){1'b0}}, on_shadow_q};
    else if (state_q == tcs_pkg::TCS_SYNC && last_tick && !wr_q)
      o_rsp_rdata <= i_core_rdata;
  end

  // ==========================================================
  // System requests
  // ==========================================================
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq <= 1'b0;
      o_evt <= '0;
      o_dma <= '0;
    end
    else
    begin
      o_irq <= i_core_irq;
      o_evt <= i_core_evt;
      o_dma <= i_core_dma;
    end
  end

  assign o_wake = o_irq && i_sleep;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_wr_take;
    take_sync && i_req_write;
  endsequence

  sequence s_rd_take;
    take_sync && !i_req_write;
  endsequence

  a_tick_in_sleep: assert property (
    (i_sleep && i_gclk_run) |-> (gap_q < GCLK_DIV))
    else $error("tick lost in sleep");
  a_wake_on_irq: assert property (
    (i_core_irq && i_sleep) |=> (o_wake || !i_sleep))
    else $error("interrupt did not wake");
  a_evt_sleep: assert property (
    i_sleep |=> o_evt == $past(i_core_evt))
    else $error("event not passed in sleep");
  a_stb_on_tick: assert property (
    o_core_wr_stb |-> $past(o_pair_tick))
    else $error("core write off tick");
  a_write_cross: assert property (
    s_wr_take |=> !o_core_wr_stb ##[1:200] (o_core_wr_stb && o_rsp_valid))
    else $error("write crossing broken");
  a_read_cross: assert property (
    s_rd_take |=> !o_rsp_valid ##[1:200] o_rsp_valid)
    else $error("read crossing broken");
  a_dma_pass: assert property (
    1'b1 |=> o_dma == $past(i_core_dma))
    else $error("dma request lost");
  a_irq_pass: assert property (
    i_core_irq |=> o_irq)
    else $error("interrupt not raised");
  a_busy_stall: assert property (
    take_sync |=> (o_busy && !o_req_ready) throughout o_busy[*2])
    else $error("no busy during crossing");

endmodule

// ===== bench/tcs_core_model.sv
// Counting core stand-in: keeps crossed writes, returns kept values.
// Assumes the shell's core-side strobe, select and data ports.
`timescale 1ns/1ps
module tcs_core_model (
  // Clock
  input wire logic i_sys_clk,
  // Core side of the shell
  input wire logic i_wr_stb,
  input wire logic [2:0] i_sel,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] regs_q [8] = '{default: 32'h0};
  always @(posedge i_sys_clk)
    if (i_wr_stb)
      regs_q[i_sel] <= i_wdata;
  assign o_rdata = regs_q[i_sel];
endmodule

// ===== bench/test_tcs_sync_shell.sv
// Self-checking bench for the timer clock-domain shell.
// Assumes the core stand-in and a 40 MHz system clock.
`timescale 1ns/1ps
module test_tcs_sync_shell;
  logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0, run = 1'b1;
  logic vld = 1'b0, wr = 1'b0, irq = 1'b0;
  logic [2:0] sel = 3'h0, evt = 3'h0, dma = 3'h0, csel, oevt, odma;
  logic [31:0] wd = 32'h0, rd, crd, cwd, seed = 32'hae2d, cs = 32'hae2d;
  logic rdy, rv, busy, tick, stb, on, oirq, wake;
  logic [32:0] e, exp_q[$];
  logic [31:0] mem [8];
  logic [6:0] p = 7'h0;
  int n_errors = 0, n_compared = 0;

  tcs_sync_shell tcs_sync_shell_i (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_sleep(sleep), .i_gclk_run(run), .i_req_valid(vld), .i_req_write(wr),
    .i_req_sel(sel), .i_req_wdata(wd), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(rd), .o_busy(busy), .o_pair_tick(tick),
    .o_core_wr_stb(stb), .o_core_sel(csel), .o_core_wdata(cwd),
    .o_core_on(on), .i_core_rdata(crd), .i_core_irq(irq),
    .i_core_evt(evt), .i_core_dma(dma), .o_irq(oirq), .o_wake(wake),
    .o_evt(oevt), .o_dma(odma));
  // Core stand-in owns the timer-side signals from the start
  tcs_core_model tcs_core_model_i (.i_sys_clk(clk), .i_wr_stb(stb),
    .i_sel(csel), .i_wdata(cwd), .o_rdata(crd));

  // Bus clock runs before the first access
  initial
    forever #12.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    n_compared++;
    if (got !== ex)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, ex);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // =========================================
  // Bus driver: waits for ready, notes answer
  task automatic req(input logic w, input logic [2:0] s,
                     input logic [31:0] d, input logic [31:0] ex);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (rdy !== 1'b1)
      n_errors++;
    vld = 1'b1;
    wr = w;
    sel = s;
    wd = d;
    exp_q.push_back({~w, ex});
    @(negedge clk);
    vld = 1'b0;
    chk(busy, w || s != 3'h7);
  endtask

  // =========================================
  // Watchers
  always @(posedge clk)
    if (rst_n && rv === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(rv, 1'b0);
      else
      begin
        e = exp_q.pop_front();
        if (e[32])
          chk(rd, e[31:0]);
      end
    end

  always @(posedge clk)
    if (rst_n)
    begin
      chk({oirq, oevt, odma}, p);
      chk(wake, oirq & sleep);
      p = {irq, evt, dma};
    end

  // Random core requests once out of reset
  always @(negedge clk)
    if (rst_n)
    begin
      cs = lfsr(cs);
      {irq, evt, dma} = cs[6:0];
    end

  // =========================================
  // Main sequence
  initial
  begin
    int k;
    logic [31:0] v;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 16; k++)
    begin
      sleep = k[3];
      seed = lfsr(seed);
      v = (k[2:0] == 3'h7) ? {31'h0, seed[0]} : seed;
      mem[k[2:0]] = v;
      req(1'b1, k[2:0], v, 32'h0);
      req(1'b0, k[2:0], 32'h0, v);
      if (k[2:0] == 3'h7)
        chk(on, v);
    end
    k = 0;
    repeat (40) @(negedge clk) k += tick;
    chk(k, 10);
    run = 1'b0;
    req(1'b0, 3'h3, 32'h0, mem[3]);
    repeat (20) @(negedge clk);
    chk(busy, 1'b1);
    run = 1'b1;
    k = 0;
    while (exp_q.size() != 0 && k < 50)
    begin
      @(negedge clk);
      k++;
    end
    chk(exp_q.size(), 0);
    end_of_test;
  end

  initial
  begin
    #75000;
    n_errors++;
    end_of_test;
  end
endmodule
